/* File: common/cpsseq_pkg.sv */
// constants shared by the configurable power stage sequencer
// assumes a single 100 MHz clock domain and an active low async reset
package cpsseq_pkg;

  // number of half-bridges, index 0..3 = half_bridge_a..half_bridge_d
  localparam int unsigned NUM_STAGES = 4;
  localparam int unsigned CODE_W     = 2;

  // stage arrangement encoding
  localparam logic ARR_HBRIDGE = 1'h0;
  localparam logic ARR_SINGLE  = 1'h1;

  // reset values of the control bits
  localparam logic       RST_ARRANGEMENT = ARR_HBRIDGE;
  localparam logic       RST_ENABLE      = 1'h0;
  localparam logic       RST_DIR         = 1'h0;
  localparam logic       RST_STEP_BIT    = 1'h0;
  localparam logic [3:0] RST_STAGE_CMD   = 4'h0;
  localparam logic [1:0] RST_POSITION    = 2'h0;

  // per-channel fault codes
  localparam logic [1:0] CODE_OK  = 2'h3;
  localparam logic [1:0] CODE_OL  = 2'h1;
  localparam logic [1:0] CODE_SCB = 2'h2;
  localparam logic [1:0] CODE_SCG = 2'h0;

  // bridge drive pattern per position, bit0 = a .. bit3 = d
  localparam logic [3:0] POS0_HS = 4'h9;
  localparam logic [3:0] POS0_LS = 4'h6;
  localparam logic [3:0] POS1_HS = 4'h5;
  localparam logic [3:0] POS1_LS = 4'hA;
  localparam logic [3:0] POS2_HS = 4'h6;
  localparam logic [3:0] POS2_LS = 4'h9;
  localparam logic [3:0] POS3_HS = 4'hA;
  localparam logic [3:0] POS3_LS = 4'h5;

endpackage

/* File: hdl/cpsseq_core.sv */
// sequencer and diagnosis latch for four configurable half-bridges
// assumes frame_* inputs come from spi logic on ref_clk_in, one pulse per frame;
// pwm pin, comparator and thermal inputs are asynchronous and get synchronised
//
// How it works
// - arrangement bit selects h-bridge, reset h-bridge
// - all stage on/off bits in one register
// - single mode: no coherency check applied
// - single mode: each switch controlled individually
// - step signal is pwm pin and bit
// - step on rising edge; disabled means off in h-bridge
// - step falling leaves conducting switches unchanged
// - direction picks four-state order, forward/reverse
// - start at a-high b-low, d-high c-low
// - h-bridge: never both switches of half
// - same-frame direction and step: old direction
// - same-frame enable and step: enable only
// - battery short detected only while on
// - ground short, open load only while off
// - overtemperature only via general thermal warning
// - diagnosis codes readable in both arrangements
// - read start clears the diagnosis codes
// - summary bit set on any stage fault
// - fault codes 11 ok 01 ol 10 scb 00 scg
`timescale 1ns/1ps
module cpsseq_core (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       frame_wr_in,
  input  wire logic       frame_arrangement_in,
  input  wire logic       frame_enable_in,
  input  wire logic       frame_dir_in,
  input  wire logic       frame_step_in,
  input  wire logic [3:0] frame_hs_cmd_in,
  input  wire logic [3:0] frame_ls_cmd_in,
  input  wire logic       pwm_pin_in,
  input  wire logic [3:0] scb_det_in,
  input  wire logic [3:0] scg_det_in,
  input  wire logic [3:0] ol_det_in,
  input  wire logic       thermal_det_in,
  input  wire logic       diag_read_start_in,
  output logic      [3:0] hs_on_out,
  output logic      [3:0] ls_on_out,
  output logic      [1:0] position_out,
  output logic            stage_arrangement_select_out,
  output logic      [7:0] diag_code_out,
  output logic            any_stage_fault_summary_out,
  output logic            general_thermal_warning_out
);

  // bridge pattern for a position index
  function automatic logic [7:0] pos_drive(input logic [1:0] pos);
    logic [7:0] r;
    r = {cpsseq_pkg::POS0_HS, cpsseq_pkg::POS0_LS};
    unique case (pos)
      2'h0: r = {cpsseq_pkg::POS0_HS, cpsseq_pkg::POS0_LS};
      2'h1: r = {cpsseq_pkg::POS1_HS, cpsseq_pkg::POS1_LS};
      2'h2: r = {cpsseq_pkg::POS2_HS, cpsseq_pkg::POS2_LS};
      2'h3: r = {cpsseq_pkg::POS3_HS, cpsseq_pkg::POS3_LS};
    endcase
    return r;
  endfunction

  // next code of one channel: read clears, a fresh fault sets, set wins
  function automatic logic [1:0] chan_code(
    input logic       on,
    input logic       clear,
    input logic       scb,
    input logic       short_to_ground,
    input logic       ol,
    input logic [1:0] held
  );
    logic [1:0] c;
    c = held;
    if (clear) begin
      c = cpsseq_pkg::CODE_OK;
    end
    if (on && scb) begin
      c = cpsseq_pkg::CODE_SCB;
    end else if (!on && c == cpsseq_pkg::CODE_OK) begin
      // first off-state fault sticks until read or until a battery short while on
      if (short_to_ground) begin
        c = cpsseq_pkg::CODE_SCG;
      end else if (ol) begin
        c = cpsseq_pkg::CODE_OL;
      end
    end
    return c;
  endfunction

  // two-stage synchronisers for all asynchronous inputs
  logic [13:0] sync1;
  logic [13:0] sync2;
  logic [13:0] next_sync1;
  logic [13:0] next_sync2;
  logic        pwm_sync;
  logic [3:0]  scb_sync;
  logic [3:0]  scg_sync;
  logic [3:0]  ol_sync;
  logic        thermal_sync;

  // only the second stage is read; the first may still be settling
  always_comb begin
    next_sync1 = {thermal_det_in, ol_det_in, scg_det_in, scb_det_in, pwm_pin_in};
    next_sync2 = sync1;
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1 <= 14'h0000;
      sync2 <= 14'h0000;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  assign pwm_sync     = sync2[0];
  assign scb_sync     = sync2[4:1];
  assign scg_sync     = sync2[8:5];
  assign ol_sync      = sync2[12:9];
  assign thermal_sync = sync2[13];

  // control bits written by frames
  logic       arrangement;
  logic       enable;
  logic       dir;
  logic       step_bit;
  logic [3:0] hs_cmd;
  logic [3:0] ls_cmd;
  logic       next_arrangement;
  logic       next_enable;
  logic       next_dir;
  logic       next_step_bit;
  logic [3:0] next_hs_cmd;
  logic [3:0] next_ls_cmd;

  always_comb begin
    next_arrangement = arrangement;
    next_enable      = enable;
    next_dir         = dir;
    next_step_bit    = step_bit;
    next_hs_cmd      = hs_cmd;
    next_ls_cmd      = ls_cmd;
    // every frame reloads the control bits, the step bit only if enable is unchanged; frames may come back to back
    if (frame_wr_in) begin
      next_arrangement = frame_arrangement_in;
      next_enable      = frame_enable_in;
      next_dir         = frame_dir_in;
      next_hs_cmd      = frame_hs_cmd_in;
      next_ls_cmd      = frame_ls_cmd_in;
      // a step bit change riding on an enable change is dropped
      if (frame_enable_in == enable) begin
        next_step_bit = frame_step_in;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      arrangement <= cpsseq_pkg::RST_ARRANGEMENT;
      enable      <= cpsseq_pkg::RST_ENABLE;
      dir         <= cpsseq_pkg::RST_DIR;
      step_bit    <= cpsseq_pkg::RST_STEP_BIT;
      hs_cmd      <= cpsseq_pkg::RST_STAGE_CMD;
      ls_cmd      <= cpsseq_pkg::RST_STAGE_CMD;
    end else begin
      arrangement <= next_arrangement;
      enable      <= next_enable;
      dir         <= next_dir;
      step_bit    <= next_step_bit;
      hs_cmd      <= next_hs_cmd;
      ls_cmd      <= next_ls_cmd;
    end
  end

  // stepping: edge of (pin and bit), direction lagged by one cycle
  logic       step_sig;
  logic       step_rise;
  logic       step_prev;
  logic       dir_applied;
  logic [1:0] position;
  logic [3:0] hs_on;
  logic [3:0] ls_on;
  logic       next_step_prev;
  logic       next_dir_applied;
  logic [1:0] next_position;
  logic [3:0] next_hs_on;
  logic [3:0] next_ls_on;
  logic [7:0] bridge;

  // step_prev resets low like the idle step signal: no false edge out of reset
  assign step_sig  = pwm_sync & step_bit;
  assign step_rise = step_sig & ~step_prev;

  always_comb begin
    next_step_prev   = step_sig;
    // the lag means a same-frame direction change misses the step it rides on
    next_dir_applied = dir;
    // position is kept while disabled, so stepping resumes where it stopped
    next_position    = position;
    if (enable && step_rise) begin
      if (dir_applied) begin
        next_position = position + 2'h1;
      end else begin
        next_position = position - 2'h1;
      end
    end
    bridge = pos_drive(next_position);
    if (arrangement == cpsseq_pkg::ARR_HBRIDGE) begin
      if (enable) begin
        next_hs_on = bridge[7:4];
        // guard kept even though every pattern is clean
        next_ls_on = bridge[3:0] & ~bridge[7:4];
      end else begin
        next_hs_on = 4'h0;
        next_ls_on = 4'h0;
      end
    end else begin
      next_hs_on = hs_cmd;
      next_ls_on = ls_cmd;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      step_prev   <= 1'h0;
      dir_applied <= cpsseq_pkg::RST_DIR;
      position    <= cpsseq_pkg::RST_POSITION;
      hs_on       <= 4'h0;
      ls_on       <= 4'h0;
    end else begin
      step_prev   <= next_step_prev;
      dir_applied <= next_dir_applied;
      position    <= next_position;
      hs_on       <= next_hs_on;
      ls_on       <= next_ls_on;
    end
  end

  // diagnosis: per-channel latched code, set wins over read clear
  wire  [7:0] diag_code;
  wire  [3:0] chan_fault;
  logic       summary;
  logic       thermal;
  logic       next_summary;
  logic       next_thermal;
  logic [3:0] stage_on;

  assign stage_on = hs_on | ls_on;

  // one latch per channel so a fault on one never masks another
  for (genvar g = 0; g < cpsseq_pkg::NUM_STAGES; g++) begin : g_chan
    logic [1:0] code;
    logic [1:0] next_code;

    always_comb begin
      next_code = chan_code(stage_on[g], diag_read_start_in, scb_sync[g], scg_sync[g],
                            ol_sync[g], code);
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        code <= cpsseq_pkg::CODE_OK;
      end else begin
        code <= next_code;
      end
    end

    assign diag_code[2*g +: 2] = code;
    assign chan_fault[g]       = (next_code != cpsseq_pkg::CODE_OK);
  end

  // thermal is reported alone and stays out of the summary
  always_comb begin
    next_summary = |chan_fault;
    next_thermal = thermal_sync;
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      summary <= 1'h0;
      thermal <= 1'h0;
    end else begin
      summary <= next_summary;
      thermal <= next_thermal;
    end
  end

  assign hs_on_out                    = hs_on;
  assign ls_on_out                    = ls_on;
  assign position_out                 = position;
  assign stage_arrangement_select_out = arrangement;
  assign diag_code_out                = diag_code;
  assign any_stage_fault_summary_out  = summary;
  assign general_thermal_warning_out  = thermal;

endmodule

/* File: tb/cpsseq_monitor.sv */
// port checks for the power stage sequencer
// assumes one clock domain; bound to cpsseq_core below
`timescale 1ns/1ps
module cpsseq_monitor (
  input wire logic       ref_clk_in,
  input wire logic       rst_b_in,
  input wire logic       pwm_pin_in,
  input wire logic [3:0] scb_det_in,
  input wire logic [3:0] scg_det_in,
  input wire logic [3:0] ol_det_in,
  input wire logic       thermal_det_in,
  input wire logic       diag_read_start_in,
  input wire logic [3:0] hs_on_out,
  input wire logic [3:0] ls_on_out,
  input wire logic [1:0] position_out,
  input wire logic       stage_arrangement_select_out,
  input wire logic [7:0] diag_code_out,
  input wire logic       any_stage_fault_summary_out,
  input wire logic       general_thermal_warning_out
);
  wire hb = !stage_arrangement_select_out;
  wire on_a = hs_on_out[0] | ls_on_out[0];
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // arrangement switch edge skipped: outputs follow one edge later
  bridge_excl_a: assert property (
    $stable(hb) && hb |-> (hs_on_out & ls_on_out) == 4'h0) else $error("shoot-through");
  bridge_order_a: assert property (
    $stable(hb) && hb && hs_on_out != 4'h0 |-> ls_on_out == ~hs_on_out && hs_on_out ==
    {~^position_out, ^position_out, position_out[1], ~position_out[1]}) else $error("pattern");
  pos_step_a: assert property (
    $changed(position_out) |-> position_out == $past(position_out) + 2'h1
    || position_out == $past(position_out) - 2'h1) else $error("position jump");
  step_cause_a: assert property (
    $changed(position_out) |-> $past(pwm_pin_in, 3)) else $error("step without pin");
  fault_sum_a: assert property (
    any_stage_fault_summary_out == (diag_code_out != 8'hFF)) else $error("summary");
  read_clear_a: assert property (
    ({scb_det_in, scg_det_in, ol_det_in} == 12'h000)[*4] ##0 diag_read_start_in
    |=> diag_code_out == 8'hFF) else $error("read kept codes");
  scb_on_a: assert property (
    $rose(diag_code_out[1:0] == 2'h2) |-> $past(on_a)) else $error("battery short while off");
  off_fault_a: assert property (
    $rose(diag_code_out[1:0] == 2'h1) |-> !$past(on_a)) else $error("open load while on");
  thermal_path_a: assert property (
    $stable(thermal_det_in)[*3] |=> general_thermal_warning_out == $past(thermal_det_in))
    else $error("thermal lag");
endmodule
bind cpsseq_core cpsseq_monitor cpsseq_monitor_i (.ref_clk_in, .rst_b_in, .pwm_pin_in,
  .scb_det_in, .scg_det_in, .ol_det_in, .thermal_det_in, .diag_read_start_in, .hs_on_out,
  .ls_on_out, .position_out, .stage_arrangement_select_out, .diag_code_out,
  .any_stage_fault_summary_out, .general_thermal_warning_out);

/* File: tb/cpsseq_host.sv */
// host model: frame writes, diagnosis reads, pwm pin
// drives on the falling clock edge; callers keep frame order
`timescale 1ns/1ps
module cpsseq_host (
  input  wire logic       ref_clk_in,
  output logic            frame_wr_out,
  output logic            arr_out,
  output logic            en_out,
  output logic            dir_out,
  output logic            step_out,
  output logic      [3:0] hs_out,
  output logic      [3:0] ls_out,
  output logic            pwm_out,
  output logic            rd_out
);
  initial begin
    {frame_wr_out, arr_out, en_out, dir_out, step_out, hs_out, ls_out, pwm_out, rd_out} = '0;
  end
  // enable, direction and step edges may share one frame
  task automatic wr(input logic [11:0] f);
    @(negedge ref_clk_in);
    {arr_out, en_out, dir_out, step_out, hs_out, ls_out} = f;
    frame_wr_out = 1'h1;
    @(negedge ref_clk_in);
    frame_wr_out = 1'h0;
    {arr_out, en_out, dir_out, step_out, hs_out, ls_out} = ~f; // no stale frame
  endtask
  task automatic rd();
    @(negedge ref_clk_in);
    rd_out = 1'h1;
    @(negedge ref_clk_in);
    rd_out = 1'h0;
  endtask
  task automatic pin(input logic v);
    @(negedge ref_clk_in);
    pwm_out = v;
  endtask
endmodule

/* File: tb/cpsseq_core_tb.sv */
// self-checking bench for the power stage sequencer
// host model drives frames and pin; bench drives detectors
`timescale 1ns/1ps
module cpsseq_core_tb;
  logic       ref_clk_in, rst_b_in, thermal_det_in, frame_wr_in, frame_arrangement_in;
  logic       frame_enable_in, frame_dir_in, frame_step_in, pwm_pin_in, diag_read_start_in;
  logic [3:0] scb_det_in, scg_det_in, ol_det_in, frame_hs_cmd_in, frame_ls_cmd_in;
  logic [3:0] hs_on_out, ls_on_out;
  logic [7:0] diag_code_out;
  logic [1:0] position_out;
  logic       stage_arrangement_select_out, any_stage_fault_summary_out;
  logic       general_thermal_warning_out;
  int         miscompares = 0, n_tests = 0;
  logic [7:0] pat [4] = '{8'h96, 8'h5A, 8'h69, 8'hA5};
  cpsseq_core cpsseq_core_i (.ref_clk_in, .rst_b_in, .frame_wr_in, .frame_arrangement_in,
    .frame_enable_in, .frame_dir_in, .frame_step_in, .frame_hs_cmd_in, .frame_ls_cmd_in,
    .pwm_pin_in, .scb_det_in, .scg_det_in, .ol_det_in, .thermal_det_in, .diag_read_start_in,
    .hs_on_out, .ls_on_out, .position_out, .stage_arrangement_select_out, .diag_code_out,
    .any_stage_fault_summary_out, .general_thermal_warning_out);
  cpsseq_host cpsseq_host_i (.ref_clk_in, .frame_wr_out(frame_wr_in),
    .arr_out(frame_arrangement_in), .en_out(frame_enable_in), .dir_out(frame_dir_in),
    .step_out(frame_step_in), .hs_out(frame_hs_cmd_in), .ls_out(frame_ls_cmd_in),
    .pwm_out(pwm_pin_in), .rd_out(diag_read_start_in));
  initial begin
    ref_clk_in = 1'h0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic fr(input logic e, d, s);
    cpsseq_host_i.wr({2'h0, e, d, s, 8'h00});
    cyc(2);
  endtask
  task automatic br(input logic [1:0] p);
    chk("position", {6'h00, p}, {6'h00, position_out});
    chk("bridge", pat[p], {hs_on_out, ls_on_out});
  endtask
  task automatic clr();
    {scb_det_in, scg_det_in, ol_det_in} = '0;
    cyc(4);
    cpsseq_host_i.rd();
    cyc(1);
    chk("cleared", 8'hFF, diag_code_out);
    chk("summary", 8'h00, {7'h00, any_stage_fault_summary_out});
  endtask
  task automatic test_done();
    $display("checks %0d wrong %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog: a hung sequence still reaches the report
  initial begin
    cyc(3000);
    miscompares++;
    test_done();
  end
  initial begin
    {rst_b_in, thermal_det_in, scb_det_in, scg_det_in, ol_det_in} = '0;
    cyc(10);
    rst_b_in = 1'h1;
    chk("arrangement", 8'h00, {7'h00, stage_arrangement_select_out});
    chk("codes", 8'hFF, diag_code_out);
    cpsseq_host_i.pin(1'h1);
    fr(1'h1, 1'h1, 1'h0);
    br(2'h0);
    for (int i = 1; i < 5; i++) begin
      fr(1'h1, 1'h1, 1'h1);
      br(2'(i));
      fr(1'h1, 1'h1, 1'h0);
      br(2'(i));
    end
    fr(1'h1, 1'h0, 1'h1);
    br(2'h1);
    fr(1'h1, 1'h0, 1'h0);
    fr(1'h1, 1'h0, 1'h1);
    br(2'h0);
    fr(1'h1, 1'h0, 1'h0);
    fr(1'h1, 1'h0, 1'h1);
    br(2'h3);
    fr(1'h1, 1'h0, 1'h0);
    fr(1'h0, 1'h0, 1'h0);
    fr(1'h0, 1'h0, 1'h1);
    fr(1'h0, 1'h0, 1'h0);
    fr(1'h1, 1'h0, 1'h1);
    br(2'h3);
    fr(1'h1, 1'h0, 1'h1);
    br(2'h2);
    $display("test stepping done");
    cpsseq_host_i.pin(1'h0);
    fr(1'h1, 1'h0, 1'h0);
    fr(1'h1, 1'h0, 1'h1);
    br(2'h2);
    cpsseq_host_i.pin(1'h1);
    cyc(4);
    br(2'h1);
    scb_det_in = 4'h1;
    cyc(4);
    chk("scb code", 8'hFE, diag_code_out);
    clr();
    fr(1'h0, 1'h0, 1'h0);
    chk("off", 8'h00, {hs_on_out, ls_on_out});
    {scb_det_in, ol_det_in, scg_det_in} = 12'h814;
    cyc(4);
    chk("off codes", 8'hCD, diag_code_out);
    chk("summary", 8'h01, {7'h00, any_stage_fault_summary_out});
    clr();
    thermal_det_in = 1'h1;
    cyc(4);
    chk("thermal", 8'h01, {7'h00, general_thermal_warning_out});
    chk("no summary", 8'h00, {7'h00, any_stage_fault_summary_out});
    thermal_det_in = 1'h0;
    $display("test diagnosis done");
    cpsseq_host_i.wr({4'h8, 4'h3, 4'h1});
    cyc(2);
    chk("single", 8'h01, {7'h00, stage_arrangement_select_out});
    chk("stages", 8'h31, {hs_on_out, ls_on_out});
    scb_det_in = 4'h2;
    cyc(4);
    chk("single code", 8'hFB, diag_code_out);
    clr();
    $display("test single done");
    test_done();
  end
endmodule
